// *** core/ttal_pkg.sv ***
// constants and types shared by the tiled texture address generator
package ttal_pkg;
  localparam int ADDR_W = 32;
  localparam int COORD_W = 12;
  // micro-tile is 64 bytes, sub-tile 1 KB, tile 4 KB
  localparam int UTILE_BYTES_LOG2 = 6;
  localparam int SUBTILE_BYTES_LOG2 = 10;
  localparam int TILE_BYTES_LOG2 = 12;
  // micro-tiles per sub-tile side (4x4 = 16 micro-tiles of 64 bytes)
  localparam int UT_PER_SUB_LOG2 = 2;
  // compressed block is 64 bits, 4x4 pixels
  localparam int CBLK_PIX_LOG2 = 2;
  // default sub-tile order per row parity: index = 2*y + x, values = slot
  localparam logic [7:0] SUB_ORDER_ODD_DEF = 8'hB4;
  localparam logic [7:0] SUB_ORDER_EVEN_DEF = 8'h1E;

  typedef enum logic [2:0]
  {
    TTAL_BPP64 = 3'b000,
    TTAL_BPP32 = 3'b001,
    TTAL_BPP16 = 3'b010,
    TTAL_BPP8 = 3'b011,
    TTAL_BPP4 = 3'b100,
    TTAL_BPP1 = 3'b101,
    TTAL_CMPR = 3'b110
  } ttal_fmt_type;

  typedef enum logic [1:0]
  {
    TTAL_ST_IDLE = 2'b00,
    TTAL_ST_CALC = 2'b01,
    TTAL_ST_DONE = 2'b10
  } ttal_state_type;
endpackage

// *** core/ttal_utile_geom.sv ***
// micro-tile geometry lookup per pixel format
module ttal_utile_geom
(
  input wire ttal_pkg::ttal_fmt_type fmt,
  output logic [2:0] ut_w_log2,
  output logic [2:0] ut_h_log2,
  output logic [2:0] pix_bits_log2
)
;
  always_comb
  begin
    // micro-tile width x height
    // depth-dependent shape
    case (fmt)
      ttal_pkg::TTAL_BPP64:
      begin
        ut_w_log2 = 3'h1;
        ut_h_log2 = 3'h2;
        pix_bits_log2 = 3'h6;
      end
      ttal_pkg::TTAL_BPP32:
      begin
        ut_w_log2 = 3'h2;
        ut_h_log2 = 3'h2;
        pix_bits_log2 = 3'h5;
      end
      ttal_pkg::TTAL_BPP16:
      begin
        ut_w_log2 = 3'h3;
        ut_h_log2 = 3'h2;
        pix_bits_log2 = 3'h4;
      end
      ttal_pkg::TTAL_BPP8:
      begin
        ut_w_log2 = 3'h3;
        ut_h_log2 = 3'h3;
        pix_bits_log2 = 3'h3;
      end
      ttal_pkg::TTAL_BPP4:
      begin
        ut_w_log2 = 3'h4;
        ut_h_log2 = 3'h3;
        pix_bits_log2 = 3'h2;
      end
      ttal_pkg::TTAL_BPP1:
      begin
        ut_w_log2 = 3'h5;
        ut_h_log2 = 3'h4;
        pix_bits_log2 = 3'h0;
      end
      // 2x4 compressed blocks of 64 bits
      ttal_pkg::TTAL_CMPR:
      begin
        ut_w_log2 = 3'h1;
        ut_h_log2 = 3'h2;
        pix_bits_log2 = 3'h6;
      end
      default:
      begin
        ut_w_log2 = 3'h2;
        ut_h_log2 = 3'h2;
        pix_bits_log2 = 3'h5;
      end
    endcase
  end
endmodule

// *** core/ttal_addr_gen.sv ***
// tiled and linear-tiled texture address generator
// Contract
// - origin is bottom-left; lowest address holds bottom-left pixel
// - every micro-tile occupies exactly 64 bytes
// - micro-tile shape depends on pixel depth
// - pixels inside a micro-tile stored row by row
// - compressed micro-tile is 2x4 blocks of 4x4 pixels
// - tiles are 4 KB made of four 1 KB sub-tiles
// - at 32 bpp sub-tile is 16x16, tile 32x32 pixels
// - tiles serpentine: odd rows left to right, even right to left
// - tiled images padded to whole tiles; strides assumed padded
// - sub-tile is a sequence of contiguous micro-tiles
// - micro-tiles in a sub-tile in raster order
// - linear-tiled layout stores micro-tiles raster across the image
// - serves texture lookup and tile buffer stores in both layouts
module ttal_addr_gen
#(
  parameter logic [7:0] SUB_ORDER_ODD = ttal_pkg::SUB_ORDER_ODD_DEF,
  parameter logic [7:0] SUB_ORDER_EVEN = ttal_pkg::SUB_ORDER_EVEN_DEF
)
(
  input wire logic core_clk,
  input wire logic srst,
  input wire logic req_valid,
  input wire logic req_linear,
  input wire ttal_pkg::ttal_fmt_type req_fmt,
  input wire logic [ttal_pkg::COORD_W-1:0] req_x,
  input wire logic [ttal_pkg::COORD_W-1:0] req_y,
  input wire logic [ttal_pkg::COORD_W-1:0] req_width,
  input wire logic [ttal_pkg::ADDR_W-1:0] req_base,
  output logic req_ready,
  output logic addr_valid,
  output logic [ttal_pkg::ADDR_W-1:0] addr_byte,
  output logic [5:0] addr_bit
);
  localparam int AW = ttal_pkg::ADDR_W;
  localparam int CW = ttal_pkg::COORD_W;

  ttal_pkg::ttal_state_type state_q, state_d;
  logic linear_q, linear_d;
  ttal_pkg::ttal_fmt_type fmt_q, fmt_d;
  logic [CW-1:0] x_q, x_d, y_q, y_d, w_q, w_d;
  logic [AW-1:0] base_q, base_d;
  logic rdy_q, rdy_d, val_q, val_d;
  logic [AW-1:0] addr_q, addr_d;
  logic [5:0] bit_q, bit_d;

  logic [2:0] ut_w_log2, ut_h_log2, pix_bits_log2;

  ttal_utile_geom u_geom
  (
    .fmt(fmt_q),
    .ut_w_log2(ut_w_log2),
    .ut_h_log2(ut_h_log2),
    .pix_bits_log2(pix_bits_log2)
  );

  // working coordinates; compressed formats address 4x4 blocks
  logic [CW-1:0] ex, ey, ew;
  logic [CW-1:0] ut_x, ut_y, in_x, in_y, ut_cols;
  logic [CW-1:0] sub_x, sub_y, tile_x, tile_y, tiles_wide;
  logic [1:0] sub_idx, sub_slot;
  logic [CW-1:0] tile_col;
  logic [AW-1:0] pix_off_bits, ut_index, ut_off, tile_index;
  logic [AW-1:0] calc_byte;
  logic odd_row;

  always_comb
  begin
    if (fmt_q == ttal_pkg::TTAL_CMPR)
    begin
      ex = x_q >> ttal_pkg::CBLK_PIX_LOG2;
      ey = y_q >> ttal_pkg::CBLK_PIX_LOG2;
      ew = w_q >> ttal_pkg::CBLK_PIX_LOG2;
    end
    else
    begin
      ex = x_q;
      ey = y_q;
      ew = w_q;
    end
    // y counts upward from the bottom row
    ut_x = ex >> ut_w_log2;
    ut_y = ey >> ut_h_log2;
    in_x = ex & ((CW'(1) << ut_w_log2) - CW'(1));
    in_y = ey & ((CW'(1) << ut_h_log2) - CW'(1));
    ut_cols = ew >> ut_w_log2;
    pix_off_bits = ((AW'(in_y) << ut_w_log2) + AW'(in_x)) << pix_bits_log2;
    // sub-tile is 4x4 micro-tiles, each contiguous
    // raster order of micro-tiles in a sub-tile
    ut_off = AW'({ut_y[1:0], ut_x[1:0]});
    sub_x = ut_x >> ttal_pkg::UT_PER_SUB_LOG2;
    sub_y = ut_y >> ttal_pkg::UT_PER_SUB_LOG2;
    tile_x = sub_x >> 1;
    tile_y = sub_y >> 1;
    // width taken as padded to whole tiles
    tiles_wide = ut_cols >> (ttal_pkg::UT_PER_SUB_LOG2 + 1);
    // bottom tile row (index 0) counts as odd
    odd_row = ~tile_y[0];
    tile_col = odd_row ? tile_x : (tiles_wide - CW'(1) - tile_x);
    tile_index = AW'(tile_y) * AW'(tiles_wide) + AW'(tile_col);
    sub_idx = {sub_y[0], sub_x[0]};
    sub_slot = odd_row ? SUB_ORDER_ODD[2*sub_idx +: 2]
                       : SUB_ORDER_EVEN[2*sub_idx +: 2];
    // linear-tiled: micro-tiles raster over the whole image
    ut_index = AW'(ut_y) * AW'(ut_cols) + AW'(ut_x);
    // four 1 KB sub-tiles per 4 KB tile
    // geometry gives 16x16 and 32x32 at 32 bpp
    if (linear_q)
      calc_byte = (ut_index << ttal_pkg::UTILE_BYTES_LOG2)
                + (pix_off_bits >> 3);
    else
      calc_byte = (tile_index << ttal_pkg::TILE_BYTES_LOG2)
                + (AW'(sub_slot) << ttal_pkg::SUBTILE_BYTES_LOG2)
                + (ut_off << ttal_pkg::UTILE_BYTES_LOG2)
                + (pix_off_bits >> 3);
  end

  always_comb
  begin
    state_d = state_q;
    linear_d = linear_q;
    fmt_d = fmt_q;
    x_d = x_q;
    y_d = y_q;
    w_d = w_q;
    base_d = base_q;
    rdy_d = rdy_q;
    val_d = 1'b0;
    addr_d = addr_q;
    bit_d = bit_q;
    case (state_q)
      ttal_pkg::TTAL_ST_IDLE:
      begin
        rdy_d = 1'b1;
        // one request port shared by lookup and store clients
        if (req_valid && rdy_q)
        begin
          linear_d = req_linear;
          fmt_d = req_fmt;
          x_d = req_x;
          y_d = req_y;
          w_d = req_width;
          base_d = req_base;
          rdy_d = 1'b0;
          state_d = ttal_pkg::TTAL_ST_CALC;
        end
      end
      ttal_pkg::TTAL_ST_CALC:
      begin
        addr_d = base_q + calc_byte;
        bit_d = 6'(pix_off_bits[2:0]);
        val_d = 1'b1;
        state_d = ttal_pkg::TTAL_ST_DONE;
      end
      ttal_pkg::TTAL_ST_DONE:
      begin
        rdy_d = 1'b1;
        state_d = ttal_pkg::TTAL_ST_IDLE;
      end
      default:
      begin
        rdy_d = 1'b0;
        state_d = ttal_pkg::TTAL_ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge core_clk)
  begin
    if (srst)
    begin
      state_q <= ttal_pkg::TTAL_ST_IDLE;
      linear_q <= 1'b0;
      fmt_q <= ttal_pkg::TTAL_BPP32;
      x_q <= '0;
      y_q <= '0;
      w_q <= '0;
      base_q <= '0;
      rdy_q <= 1'b0;
      val_q <= 1'b0;
      addr_q <= '0;
      bit_q <= '0;
    end
    else
    begin
      state_q <= state_d;
      linear_q <= linear_d;
      fmt_q <= fmt_d;
      x_q <= x_d;
      y_q <= y_d;
      w_q <= w_d;
      base_q <= base_d;
      rdy_q <= rdy_d;
      val_q <= val_d;
      addr_q <= addr_d;
      bit_q <= bit_d;
    end
  end

  assign req_ready = rdy_q;
  assign addr_valid = val_q;
  assign addr_byte = addr_q;
  assign addr_bit = bit_q;

  a_origin_base: assert property (@(posedge core_clk) disable iff (srst)
    (req_valid && req_ready && req_x == '0 && req_y == '0)
    |-> ##2 addr_valid && addr_byte == $past(req_base, 2))
    else $error("origin pixel not at base address");
  // micro-tile size in linear layout at 32 bpp
  a_utile_step: assert property (@(posedge core_clk) disable iff (srst)
    (req_valid && req_ready && req_linear
     && req_fmt == ttal_pkg::TTAL_BPP32 && req_x == 12'h004
     && req_y == '0)
    |-> ##2 addr_byte == $past(req_base, 2) + 32'h40)
    else $error("next micro-tile not 64 bytes on");
  // row step inside a micro-tile at 32 bpp
  a_row_step: assert property (@(posedge core_clk) disable iff (srst)
    (req_valid && req_ready && req_fmt == ttal_pkg::TTAL_BPP32
     && req_x == '0 && req_y == 12'h001)
    |-> ##2 addr_byte == $past(req_base, 2) + 32'h10)
    else $error("row step inside micro-tile wrong");
  // raster micro-tile order in tiled layout
  a_utile_raster: assert property (@(posedge core_clk) disable iff (srst)
    (req_valid && req_ready && !req_linear
     && req_fmt == ttal_pkg::TTAL_BPP32 && req_x == '0
     && req_y == 12'h004 && req_width == 12'h020)
    |-> ##2 addr_byte - $past(req_base, 2) == 32'h100)
    else $error("micro-tile raster order wrong");
  a_answer_two: assert property (@(posedge core_clk) disable iff (srst)
    (req_valid && req_ready) |=> !req_ready
      ##1 (addr_valid && !req_ready))
    else $error("answer not two cycles after request");
  a_valid_pulse: assert property (@(posedge core_clk) disable iff (srst)
    addr_valid |=> !addr_valid)
    else $error("answer valid longer than one cycle");
  a_ready_back: assert property (@(posedge core_clk) disable iff (srst)
    addr_valid |=> req_ready)
    else $error("ready not back after answer");
  a_reset_quiet: assert property (@(posedge core_clk)
    srst |=> !addr_valid && !req_ready)
    else $error("outputs active right after reset");
  // byte-sized depths carry no bit offset
  a_bit_aligned: assert property (@(posedge core_clk) disable iff (srst)
    (addr_valid && fmt_q != ttal_pkg::TTAL_BPP4
     && fmt_q != ttal_pkg::TTAL_BPP1) |-> addr_bit == '0)
    else $error("bit offset set for byte-sized pixel");
  // next tile along a row is 4 KB on
  a_tile_next: assert property (@(posedge core_clk) disable iff (srst)
    (req_valid && req_ready && !req_linear
     && req_fmt == ttal_pkg::TTAL_BPP32 && req_x == 12'h020
     && req_y == '0 && req_width == 12'h040)
    |-> ##2 addr_byte - $past(req_base, 2) == 32'h1000)
    else $error("next tile not 4 KB on");
  // second sub-tile of an odd row
  a_sub_next: assert property (@(posedge core_clk) disable iff (srst)
    (req_valid && req_ready && !req_linear
     && req_fmt == ttal_pkg::TTAL_BPP32 && req_x == 12'h010
     && req_y == '0 && req_width == 12'h040)
    |-> ##2 addr_byte - $past(req_base, 2) == 32'h400)
    else $error("odd-row sub-tile order wrong");
  a_linear_row: assert property (@(posedge core_clk) disable iff (srst)
    (req_valid && req_ready && req_linear
     && req_fmt == ttal_pkg::TTAL_BPP32 && req_x == '0
     && req_y == 12'h004 && req_width == 12'h040)
    |-> ##2 addr_byte - $past(req_base, 2) == 32'h400)
    else $error("linear-tiled row step wrong");
  // third tile row walks left to right again
  a_odd_two: assert property (@(posedge core_clk) disable iff (srst)
    (req_valid && req_ready && !req_linear
     && req_fmt == ttal_pkg::TTAL_BPP32 && req_x == '0
     && req_y == 12'h040 && req_width == 12'h040)
    |-> ##2 addr_byte - $past(req_base, 2) == 32'h4000)
    else $error("third tile row not left to right");
  // even tile row starts at right end
  a_serp_even: assert property (@(posedge core_clk) disable iff (srst)
    (req_valid && req_ready && !req_linear
     && req_fmt == ttal_pkg::TTAL_BPP32 && req_x == '0
     && req_y == 12'h020 && req_width == 12'h040)
    |-> ##2 addr_byte - $past(req_base, 2) == 32'h3800)
    else $error("even tile row not walked right to left");
  a_cmpr_block: assert property (@(posedge core_clk) disable iff (srst)
    (req_valid && req_ready && req_linear
     && req_fmt == ttal_pkg::TTAL_CMPR && req_x == 12'h004
     && req_y == '0)
    |-> ##2 addr_byte == $past(req_base, 2) + 32'h8)
    else $error("compressed block not 8 bytes on");

  c_tiled: cover property (@(posedge core_clk) disable iff (srst)
    req_valid && req_ready && !req_linear ##2 addr_valid);
  c_linear: cover property (@(posedge core_clk) disable iff (srst)
    req_valid && req_ready && req_linear ##2 addr_valid);
  c_cmpr: cover property (@(posedge core_clk) disable iff (srst)
    req_valid && req_ready && req_fmt == ttal_pkg::TTAL_CMPR);
  // upper tile rows and sub-byte pixels
  c_upper_row: cover property (@(posedge core_clk) disable iff (srst)
    req_valid && req_ready && !req_linear && req_y >= 12'h020);
  c_subpix: cover property (@(posedge core_clk) disable iff (srst)
    addr_valid && addr_bit != '0);
endmodule

// *** verification/ttal_req_model.sv ***
// requester model that stands in for the lookup and tile buffer units
module ttal_req_model
(
  input wire logic core_clk,
  input wire logic srst,
  input wire logic go,
  input wire logic lin,
  input wire ttal_pkg::ttal_fmt_type fmt,
  input wire logic [11:0] x,
  input wire logic [11:0] y,
  input wire logic [11:0] w,
  input wire logic [31:0] b,
  input wire logic req_ready,
  output logic req_valid,
  output logic req_linear,
  output ttal_pkg::ttal_fmt_type req_fmt,
  output logic [11:0] req_x,
  output logic [11:0] req_y,
  output logic [11:0] req_width,
  output logic [31:0] req_base
);
  timeunit 1ns;
  timeprecision 100ps;
  initial
  begin
    req_valid = 1'b0;
    {req_linear, req_x, req_y, req_width, req_base} = '0;
    req_fmt = ttal_pkg::TTAL_BPP32;
  end
  always @(posedge core_clk)
  begin
    if (srst)
    begin
      req_valid <= 1'b0;
    end
    else if (go && !req_valid)
    begin
      req_valid <= 1'b1;
      req_linear <= lin;
      req_fmt <= fmt;
      req_x <= x;
      req_y <= y;
      req_width <= w;
      req_base <= b;
    end
    else if (req_valid && req_ready)
    begin
      // released lines show the inverse so stale data cannot pass
      req_valid <= 1'b0;
      req_linear <= ~req_linear;
      req_fmt <= ttal_pkg::ttal_fmt_type'(~req_fmt);
      req_x <= ~req_x;
      req_y <= ~req_y;
      req_width <= ~req_width;
      req_base <= ~req_base;
    end
  end
endmodule

// *** verification/tb_top.sv ***
// self-checking bench for the tiled texture address generator
module tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  localparam logic [31:0] BASE = 32'h00100000;
  localparam int WT[7] = '{1, 2, 3, 3, 4, 5, 1};
  localparam int HT[7] = '{2, 2, 2, 3, 3, 4, 2};
  localparam int PT[7] = '{6, 5, 4, 3, 2, 0, 6};
  localparam int TF[11] = '{1, 1, 1, 1, 1, 1, 1, 1, 3, 6, 5};
  localparam int TX[11] = '{0, 5, 20, 0, 20, 40, 0, 40, 70, 70, 300};
  localparam int TY[11] = '{0, 3, 0, 20, 20, 0, 40, 40, 65, 90, 140};
  localparam int TW[11] = '{64, 64, 64, 64, 64, 64, 64, 64, 128, 128, 512};
  localparam int SL[10] = '{1, 0, 0, 0, 1, 0, 0, 1, 0, 0};
  localparam int SF[10] = '{1, 1, 1, 1, 6, 1, 1, 1, 1, 3};
  localparam int SX[10] = '{4, 0, 0, 0, 4, 32, 16, 0, 0, 0};
  localparam int SY[10] = '{0, 1, 4, 32, 0, 0, 0, 4, 64, 0};
  localparam int SW[10] = '{64, 64, 32, 64, 64, 64, 64, 64, 64, 64};
  localparam logic [31:0] SE[10] = '{32'h40, 32'h10, 32'h100, 32'h3800,
    32'h8, 32'h1000, 32'h400, 32'h400, 32'h4000, 32'h0};
  logic core_clk = 1'b0;
  logic srst = 1'b1;
  logic go = 1'b0;
  logic lin = 1'b0;
  ttal_pkg::ttal_fmt_type fmt = ttal_pkg::TTAL_BPP32;
  logic [11:0] x = '0;
  logic [11:0] y = '0;
  logic [11:0] w = '0;
  logic [31:0] b = '0;
  logic req_valid, req_linear, req_ready, addr_valid;
  ttal_pkg::ttal_fmt_type req_fmt;
  logic [11:0] req_x, req_y, req_width;
  logic [31:0] req_base, addr_byte;
  logic [5:0] addr_bit;
  int error_cnt = 0;
  int n_tests = 0;
  initial
  begin
    forever #4 core_clk = ~core_clk;
  end
  ttal_req_model req_u (.core_clk(core_clk), .srst(srst), .go(go),
    .lin(lin), .fmt(fmt), .x(x), .y(y), .w(w), .b(b),
    .req_ready(req_ready), .req_valid(req_valid), .req_linear(req_linear),
    .req_fmt(req_fmt), .req_x(req_x), .req_y(req_y),
    .req_width(req_width), .req_base(req_base));
  ttal_addr_gen dut_u (.core_clk(core_clk), .srst(srst),
    .req_valid(req_valid), .req_linear(req_linear), .req_fmt(req_fmt),
    .req_x(req_x), .req_y(req_y), .req_width(req_width),
    .req_base(req_base), .req_ready(req_ready), .addr_valid(addr_valid),
    .addr_byte(addr_byte), .addr_bit(addr_bit));
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e,
    input string m);
    n_tests++;
    if (g !== e)
    begin
      error_cnt++;
      $display("CHECK FAILED %0t %s got %0h want %0h", $time, m, g, e);
    end
  endtask
  // expected byte offset from base; bit offset returned in bo
  function automatic int ea(input logic l, input int f, input int xi,
    input int yi, input int wi, output int bo);
    int wl, hl, ux, uy, tw, ty, s, a;
    wl = WT[f];
    hl = HT[f];
    if (f == 6)
    begin
      xi = xi / 4;
      yi = yi / 4;
      wi = wi / 4;
    end
    ux = xi >> wl;
    uy = yi >> hl;
    a = (((yi % (1 << hl)) << wl) + xi % (1 << wl)) << PT[f];
    bo = a % 8;
    a = a / 8;
    if (l)
      return a + (uy * (wi >> wl) + ux) * 64;
    tw = wi >> (wl + 3);
    ty = uy >> 3;
    s = 2 * ((uy >> 2) & 1) + ((ux >> 2) & 1);
    s = ((ty % 2 ? ttal_pkg::SUB_ORDER_EVEN_DEF :
      ttal_pkg::SUB_ORDER_ODD_DEF) >> (2 * s)) & 3;
    a += s * 1024 + ((uy & 3) * 4 + (ux & 3)) * 64;
    if (ty % 2)
      a += (ty * tw + tw - 1 - (ux >> 3)) * 4096;
    else
      a += (ty * tw + (ux >> 3)) * 4096;
    return a;
  endfunction
  task automatic rq(input logic l, input int f, input int xi, input int yi,
    input int wi, output logic [31:0] ga, output logic [5:0] gb);
    int k;
    @(posedge core_clk);
    lin <= l;
    fmt <= ttal_pkg::ttal_fmt_type'(f);
    x <= 12'(xi);
    y <= 12'(yi);
    w <= 12'(wi);
    b <= BASE;
    go <= 1'b1;
    @(posedge core_clk);
    go <= 1'b0;
    #1;
    k = 0;
    while (req_valid === 1'b1 && k < 20)
    begin
      @(posedge core_clk);
      #1;
      k++;
    end
    if (k == 20)
    begin
      error_cnt++;
      print_verdict();
    end
    k = 0;
    while (addr_valid !== 1'b1 && k < 20)
    begin
      @(posedge core_clk);
      #1;
      k++;
    end
    if (k == 20)
    begin
      error_cnt++;
      print_verdict();
    end
    // valid is seen one edge after the take, sampled high at the second
    chk(k, 1, "answer latency");
    chk(req_ready, 0, "ready during answer");
    ga = addr_byte;
    gb = addr_bit;
    @(posedge core_clk);
    #1;
    chk(addr_valid, 0, "valid pulse length");
    chk(addr_byte, ga, "address holds");
  endtask
  task automatic t_reset();
    repeat (2) @(posedge core_clk);
    srst <= 1'b0;
    #1;
    chk({req_ready, addr_valid, addr_bit}, 8'h00, "reset flags");
    chk(addr_byte, 32'h00000000, "reset address");
    @(posedge core_clk);
    #1;
    chk(req_ready, 1, "ready after first edge");
    @(posedge core_clk);
    #1;
    chk(req_ready, 1, "ready holds at second edge");
    $display("test reset done");
  endtask
  task automatic t_linear();
    logic [31:0] ga;
    logic [5:0] gb;
    int e, bo;
    // every depth and the compressed format, one spot each
    for (int f = 0; f < 7; f++)
    begin
      rq(1'b1, f, 37, 21, 64, ga, gb);
      e = ea(1'b1, f, 37, 21, 64, bo);
      chk(ga, BASE + e, "linear byte");
      chk(gb, bo, "linear bit");
    end
    $display("test linear done");
  endtask
  task automatic t_tiled();
    logic [31:0] ga;
    logic [5:0] gb;
    int e, bo;
    // sub-tiles, both tile rows and columns, several depths
    for (int i = 0; i < 11; i++)
    begin
      rq(1'b0, TF[i], TX[i], TY[i], TW[i], ga, gb);
      e = ea(1'b0, TF[i], TX[i], TY[i], TW[i], bo);
      chk(ga, BASE + e, "tiled byte");
      chk(gb, bo, "tiled bit");
    end
    $display("test tiled done");
  endtask
  task automatic t_spots();
    logic [31:0] ga;
    logic [5:0] gb;
    // hand-worked addresses at tile, sub-tile and micro-tile seams
    for (int i = 0; i < 10; i++)
    begin
      rq(SL[i] == 1, SF[i], SX[i], SY[i], SW[i], ga, gb);
      chk(ga, BASE + SE[i], "spot byte");
      chk(gb, 6'h00, "spot bit");
    end
    $display("test spots done");
  endtask
  initial
  begin
    t_reset();
    t_linear();
    t_tiled();
    t_spots();
    print_verdict();
  end
endmodule
